// ===== hw/ctis_pkg.sv
// Package of the trap and interrupt sequencer: register map, field
// positions, entry addresses and reset values.
// Assumes a 32-bit APB register bus and 16-bit instruction store addresses.
package ctis_pkg;
    // Instruction store address width
    localparam int CTIS_AW = 16;
    // Depth of the restore FIFO, one entry per pipeline stage
    localparam int CTIS_DEPTH = 3;
    // APB byte offsets
    localparam logic [7:0] CTIS_OFF_CTRL = 8'h00;
    localparam logic [7:0] CTIS_OFF_STATUS = 8'h04;
    localparam logic [7:0] CTIS_OFF_CLEAR = 8'h08;
    localparam logic [7:0] CTIS_OFF_ENABLE = 8'h0C;
    localparam logic [7:0] CTIS_OFF_RECV = 8'h10;
    // Control array one bit positions
    localparam int CTIS_NIE_BIT = 10;
    localparam int CTIS_TIND_BIT = 11;
    localparam int CTIS_FROZEN_BIT = 0;
    // Event bits of status, clear and enable registers
    localparam int CTIS_EV_TRAP = 0;
    localparam int CTIS_EV_INT = 1;
    localparam int CTIS_EV_RESTORE = 2;
    localparam int CTIS_NUM_EV = 3;
    // Entry addresses forced into the control register
    localparam logic [15:0] CTIS_TRAP_ENTRY = 16'h0000;
    localparam logic [15:0] CTIS_INT_ENTRY = 16'h0002;
    // Internal register that reads the restore FIFO
    localparam logic [6:0] CTIS_IRU_RESTORE = 7'h08;
    // Scratch-pad pseudo external registers, 32 to 38
    localparam logic [6:0] CTIS_SPAD_LO = 7'h20;
    localparam logic [6:0] CTIS_SPAD_HI = 7'h26;
    // Reset values
    localparam logic CTIS_NIE_RST = 1'b0;
    localparam logic CTIS_TIND_RST = 1'b0;
    localparam logic [2:0] CTIS_EN_RST = 3'h0;
    // Restore step counter
    typedef enum logic [1:0] {
        CTIS_STEP0 = 2'b00,
        CTIS_STEP1 = 2'b01,
        CTIS_STEP2 = 2'b10
    } ctis_step_t;
endpackage

// ===== hw/ctis_fifo_if.sv
// Interface between the sequencer and its restore FIFO storage.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface ctis_fifo_if;
    // High while the FIFO follows the pipeline
    logic capture;
    // Live pipeline addresses: 0 execute, 1 interpret, 2 fetch
    logic [ctis_pkg::CTIS_AW-1:0] live [ctis_pkg::CTIS_DEPTH];
    // Addresses held by the FIFO
    logic [ctis_pkg::CTIS_AW-1:0] held [ctis_pkg::CTIS_DEPTH];
    modport ctl (output capture, output live, input held);
    modport store (input capture, input live, output held);
endinterface
`default_nettype wire

// ===== hw/ctis_sync2.sv
// Two flip-flop synchroniser for asynchronous pin levels.
// Assumes the pins are slow levels; pulses shorter than a clock may be lost.
`timescale 1ns/100ps
`default_nettype none
module ctis_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage, read only by the second
    logic [W-1:0] meta;

    // Both stages preset to the idle level
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // ctis_sync2
`default_nettype wire

// ===== hw/ctis_restore_fifo.sv
// Restore FIFO storage: follows the pipeline addresses while capture is
// high and holds them while it is low.
// Assumes the sequencer drives capture and indexes the held entries.
`timescale 1ns/100ps
`default_nettype none
module ctis_restore_fifo (
    input wire logic sys_clk,
    input wire logic arst_n,
    ctis_fifo_if.store fif
);
    // Clock gating modelled as a load enable on the entries
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < ctis_pkg::CTIS_DEPTH; i++)
                fif.held[i] <= '0;
        end
        else if (fif.capture)
        begin
            for (int i = 0; i < ctis_pkg::CTIS_DEPTH; i++)
                fif.held[i] <= fif.live[i];
        end
    end
endmodule // ctis_restore_fifo
`default_nettype wire

// ===== hw/ctis_sequencer.sv
// Trap and interrupt sequencer of the processor, with APB status port.
// Assumes pipeline strobes are one-cycle pulses on sys_clk; trap and
// interrupt pins are asynchronous and active low.
// How it works
// RULE1: Trap with indicator clear jumps to 0000.
// RULE2: Trap sets indicator, leaves interrupt enable alone.
// RULE3: Trap keeps execute, flushes fetch/interpret, halts.
// RULE4: Qualified interrupt jumps to 0002, clears enable.
// RULE5: Simultaneous trap beats interrupt.
// RULE6: Taking either freezes the restore FIFO.
// RULE7: FIFO holds three addresses, read via register 08.
// RULE8: Each restore loads one saved address.
// RULE9: Third restore with pending event keeps FIFO frozen.
// RULE10: Restore clears indicator, sets enable, then re-evaluates.
// RULE11: Scratch-pad accesses are memory transfers, select deasserted.
// RULE12: Scratch-pad transfer-in launches read; receive captures data.
// RULE13: Pins pass a two-stage synchroniser first.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ctis_sequencer (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic trap_n_pin,
    input wire logic int_n_pin,
    input wire logic [15:0] pipe_exec_addr,
    input wire logic [15:0] pipe_interp_addr,
    input wire logic [15:0] pipe_fetch_addr,
    input wire logic interp_interruptible,
    input wire logic restore_return_op,
    input wire logic transfer_in_internal_op,
    input wire logic [6:0] iru_addr,
    input wire logic transfer_in_external_op,
    input wire logic [6:0] ext_unit_addr,
    input wire logic receive_op,
    input wire logic [31:0] proc_mem_bus_rdata,
    output logic cr_load,
    output logic [15:0] cr_load_addr,
    output logic pipe_flush,
    output logic pipe_halt,
    output logic [15:0] restore_fifo_port,
    output logic restore_fifo_valid,
    output logic mem_read_start,
    output logic ext_reg_select,
    output logic [6:0] ext_reg_addr,
    output logic [31:0] receive_data,
    output logic trap_indicator,
    output logic normal_int_enable,
    output logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // Synchronised pin levels, still active low
    logic trap_n_s;
    logic int_n_s;
    // Restore FIFO link
    ctis_fifo_if fif ();
    // FIFO frozen flag
    logic frozen;
    // Restore step and transfer-in read index
    ctis_pkg::ctis_step_t ret_step;
    logic [1:0] rd_idx;
    // Event status and enables
    logic [2:0] ev_status;
    logic [2:0] ev_enable;
    // One trap cycle delayed, for the halt step
    logic flush_d;

    // Pins pass two flops before any decision
    ctis_sync2 #(.W(2), .RST_VAL(2'h3)) u_sync ( // RULE13
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d({trap_n_pin, int_n_pin}),
        .q({trap_n_s, int_n_s})
    );

    // FIFO storage
    ctis_restore_fifo u_fifo (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .fif(fif)
    );

    // Live pipeline addresses and the capture enable
    assign fif.live[0] = pipe_exec_addr; // RULE7
    assign fif.live[1] = pipe_interp_addr;
    assign fif.live[2] = pipe_fetch_addr;
    assign fif.capture = !frozen; // RULE6

    // Recognition terms; a restore lifts the indicator for one look
    logic trap_req;
    logic int_req;
    logic gate_open;
    logic take_trap;
    logic take_int;
    logic third_ret;
    assign trap_req = !trap_n_s;
    assign int_req = !int_n_s;
    assign gate_open = !trap_indicator || restore_return_op; // RULE10
    assign take_trap = trap_req && gate_open; // RULE1
    assign take_int = int_req && gate_open && !take_trap // RULE5
        && (normal_int_enable || restore_return_op) && interp_interruptible; // RULE4
    assign third_ret = restore_return_op && (ret_step == ctis_pkg::CTIS_STEP2);

    // APB strobes: one wait state so read data comes from a flop
    logic acc;
    logic wr_go;
    logic rd_go;
    logic mapped;
    assign acc = psel && penable;
    assign wr_go = acc && pready && pwrite;
    assign rd_go = acc && !pready && !pwrite;
    always_comb
    begin
        case (paddr)
            ctis_pkg::CTIS_OFF_CTRL,
            ctis_pkg::CTIS_OFF_STATUS,
            ctis_pkg::CTIS_OFF_CLEAR,
            ctis_pkg::CTIS_OFF_ENABLE,
            ctis_pkg::CTIS_OFF_RECV: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Trap indicator: set on trap, cleared by restore then re-set
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            trap_indicator <= ctis_pkg::CTIS_TIND_RST;
        else if (take_trap)
            trap_indicator <= 1'b1; // RULE2
        else if (restore_return_op)
            trap_indicator <= 1'b0; // RULE10
    end

    // Interrupt enable: hardware wins over a software write
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            normal_int_enable <= ctis_pkg::CTIS_NIE_RST;
        else if (restore_return_op)
            normal_int_enable <= !int_req; // RULE10
        else if (take_int)
            normal_int_enable <= 1'b0; // RULE4
        else if (wr_go && paddr == ctis_pkg::CTIS_OFF_CTRL)
            normal_int_enable <= pwdata[ctis_pkg::CTIS_NIE_BIT];
        // Trap leaves it untouched
    end

    // Control register load: entry address or saved address
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cr_load <= 1'b0;
            cr_load_addr <= '0;
        end
        else if (take_trap)
        begin
            cr_load <= 1'b1;
            cr_load_addr <= ctis_pkg::CTIS_TRAP_ENTRY; // RULE1
        end
        else if (take_int)
        begin
            cr_load <= 1'b1;
            cr_load_addr <= ctis_pkg::CTIS_INT_ENTRY; // RULE4
        end
        else if (restore_return_op)
        begin
            // Oldest stage first: execute, interpret, fetch
            cr_load <= 1'b1;
            cr_load_addr <= fif.held[ret_step]; // RULE8
        end
        else
            cr_load <= 1'b0;
    end

    // Pipeline control on a trap: flush, advance once, then halt
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pipe_flush <= 1'b0;
            flush_d <= 1'b0;
            pipe_halt <= 1'b0;
        end
        else
        begin
            pipe_flush <= take_trap; // RULE3
            flush_d <= pipe_flush;
            if (flush_d)
                pipe_halt <= 1'b1; // RULE3
            else if (restore_return_op)
                pipe_halt <= 1'b0;
        end
    end

    // Freeze and restart of the restore FIFO
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            frozen <= 1'b0;
        else if (take_trap || take_int)
            frozen <= 1'b1; // RULE6 RULE9
        else if (third_ret)
            frozen <= 1'b0; // RULE8
    end

    // Restore step counter, wraps after the third restore
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ret_step <= ctis_pkg::CTIS_STEP0;
        else if (restore_return_op)
        begin
            case (ret_step)
                ctis_pkg::CTIS_STEP0: ret_step <= ctis_pkg::CTIS_STEP1;
                ctis_pkg::CTIS_STEP1: ret_step <= ctis_pkg::CTIS_STEP2;
                ctis_pkg::CTIS_STEP2: ret_step <= ctis_pkg::CTIS_STEP0;
                default: ret_step <= ctis_pkg::CTIS_STEP0;
            endcase
        end
    end

    // Transfer-in from internal register 08 walks the three entries
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_idx <= 2'h0;
            restore_fifo_port <= '0;
            restore_fifo_valid <= 1'b0;
        end
        else
        begin
            restore_fifo_valid <= 1'b0;
            if (take_trap || take_int)
                rd_idx <= 2'h0;
            else if (transfer_in_internal_op && iru_addr == ctis_pkg::CTIS_IRU_RESTORE)
            begin
                restore_fifo_port <= fif.held[rd_idx]; // RULE7
                restore_fifo_valid <= 1'b1;
                rd_idx <= (rd_idx == 2'h2) ? 2'h0 : rd_idx + 2'h1;
            end
        end
    end

    // External transfer-in: scratch pad goes out as a memory read
    logic spad_hit;
    assign spad_hit = ext_unit_addr >= ctis_pkg::CTIS_SPAD_LO
        && ext_unit_addr <= ctis_pkg::CTIS_SPAD_HI;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_read_start <= 1'b0;
            ext_reg_select <= 1'b0;
            ext_reg_addr <= '0;
        end
        else
        begin
            mem_read_start <= transfer_in_external_op && spad_hit; // RULE12
            ext_reg_select <= transfer_in_external_op && !spad_hit; // RULE11
            if (transfer_in_external_op)
                ext_reg_addr <= ext_unit_addr;
        end
    end

    // Only a receive captures memory data, never the transfer-in
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            receive_data <= '0;
        else if (receive_op)
            receive_data <= proc_mem_bus_rdata; // RULE12
    end

    // Sticky events; a set in the clear cycle survives
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    assign ev_set = {third_ret, take_int, take_trap};
    assign ev_clr = (wr_go && paddr == ctis_pkg::CTIS_OFF_CLEAR) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ev_status <= 3'h0;
        else
            ev_status <= (ev_status & ~ev_clr) | ev_set;
    end

    // Enable register and the level interrupt
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ev_enable <= ctis_pkg::CTIS_EN_RST;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_go && paddr == ctis_pkg::CTIS_OFF_ENABLE)
                ev_enable <= pwdata[2:0];
            irq <= |(ev_status & ev_enable);
        end
    end

    // APB answer: pready one cycle into the access phase
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= acc && !pready;
            pslverr <= acc && !pready && !mapped;
            prdata <= '0;
            if (rd_go)
            begin
                case (paddr)
                    ctis_pkg::CTIS_OFF_CTRL:
                    begin
                        prdata[ctis_pkg::CTIS_NIE_BIT] <= normal_int_enable;
                        prdata[ctis_pkg::CTIS_TIND_BIT] <= trap_indicator;
                        prdata[ctis_pkg::CTIS_FROZEN_BIT] <= frozen;
                    end
                    ctis_pkg::CTIS_OFF_STATUS: prdata[2:0] <= ev_status;
                    ctis_pkg::CTIS_OFF_ENABLE: prdata[2:0] <= ev_enable;
                    ctis_pkg::CTIS_OFF_RECV: prdata <= receive_data;
                    default: prdata <= '0; // Clear and unmapped read zero
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence trap_seen_s;
        trap_req && !trap_indicator && !restore_return_op;
    endsequence
    sequence flush_then_halt_s;
        pipe_flush ##2 pipe_halt;
    endsequence

    trap_entry_a: assert property (trap_seen_s |=> cr_load && cr_load_addr == 16'h0000) // RULE1
        else $error("trap did not jump to entry 0000");
    trap_nie_a: assert property (take_trap && !restore_return_op |=> // RULE2
        trap_indicator && normal_int_enable == $past(normal_int_enable))
        else $error("trap changed interrupt enable");
    trap_halt_a: assert property (take_trap |=> flush_then_halt_s) // RULE3
        else $error("trap flush and halt order wrong");
    int_entry_a: assert property (take_int |=> cr_load_addr == 16'h0002 // RULE4
        && !normal_int_enable)
        else $error("interrupt entry wrong");
    trap_first_a: assert property (trap_req && int_req && gate_open |=> // RULE5
        cr_load_addr == 16'h0000)
        else $error("interrupt beat trap");
    fifo_freeze_a: assert property ((take_trap || take_int) |=> frozen ##1 // RULE6
        $stable(fif.held[0]))
        else $error("FIFO kept clocking after a take");
    ret_load_a: assert property (restore_return_op && !take_trap && !take_int |=> // RULE8
        cr_load && cr_load_addr == $past(fif.held[ret_step]))
        else $error("restore loaded wrong address");
    third_keep_a: assert property (third_ret && (take_trap || take_int) |=> frozen) // RULE9
        else $error("FIFO restarted with event pending");
    ret_flags_a: assert property (restore_return_op |=> // RULE10
        normal_int_enable == !$past(int_req) && trap_indicator == $past(trap_req))
        else $error("restore flag update wrong");
    spad_bus_a: assert property (transfer_in_external_op && spad_hit |=> // RULE11
        mem_read_start && !ext_reg_select)
        else $error("scratch pad went out as register transfer");
    recv_only_a: assert property (!receive_op |=> $stable(receive_data)) // RULE12
        else $error("data captured without receive");
    pin_delay_a: assert property (!trap_indicator && $fell(trap_n_s) |-> // RULE13
        $past(!trap_n_pin, 2))
        else $error("trap pin not synchronised");
endmodule // ctis_sequencer
`default_nettype wire

// ===== testbench/ctis_far_model.sv
// Far-side model: trap and interrupt sources and the memory that
// answers scratch-pad reads. Assumes one clock shared with the sequencer.
`timescale 1ns/100ps
`default_nettype none
module ctis_far_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic want_trap,
    input wire logic want_int,
    input wire logic mem_read_start,
    input wire logic [31:0] mem_word,
    output logic trap_n_pin,
    output logic int_n_pin,
    output logic [31:0] proc_mem_bus_rdata
);
    // Requests are active-low levels
    assign trap_n_pin = !want_trap;
    assign int_n_pin = !want_int;
    // Memory answers for one cycle only, then shows the inverse
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            proc_mem_bus_rdata <= 32'hFFFFFFFF;
        end
        else if (mem_read_start)
        begin
            proc_mem_bus_rdata <= mem_word;
        end
        else
        begin
            proc_mem_bus_rdata <= ~mem_word;
        end
    end
endmodule // ctis_far_model
`default_nettype wire

// ===== testbench/ctis_sequencer_tb_top.sv
// Self-checking bench of the trap and interrupt sequencer.
// Assumes ctis_far_model and the design under hw/.
`timescale 1ns/100ps
`default_nettype none
module ctis_sequencer_tb_top;
    logic sys_clk, arst_n, trap_n_pin, int_n_pin, want_trap, want_int;
    logic [15:0] pipe_exec_addr, pipe_interp_addr, pipe_fetch_addr;
    logic interp_interruptible, restore_return_op, transfer_in_internal_op;
    logic transfer_in_external_op, receive_op, cr_load, pipe_flush, pipe_halt;
    logic restore_fifo_valid, mem_read_start, ext_reg_select, trap_indicator;
    logic normal_int_enable, irq, psel, penable, pwrite, pready, pslverr;
    logic [6:0] iru_addr, ext_unit_addr, ext_reg_addr;
    logic [31:0] proc_mem_bus_rdata, receive_data, pwdata, prdata, mem_word, rd;
    logic [15:0] cr_load_addr, restore_fifo_port;
    logic [7:0] paddr;
    // Expected FIFO contents; sampled pulse values
    logic [15:0] q[$];
    logic seen, flushed, err;
    logic [31:0] seed = 32'h00000047;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    int m_nie = 0;

    ctis_sequencer ctis_sequencer_i (.sys_clk, .arst_n, .trap_n_pin, .int_n_pin,
        .pipe_exec_addr, .pipe_interp_addr, .pipe_fetch_addr, .interp_interruptible,
        .restore_return_op, .transfer_in_internal_op, .iru_addr, .transfer_in_external_op,
        .ext_unit_addr, .receive_op, .proc_mem_bus_rdata, .cr_load, .cr_load_addr, .pipe_flush,
        .pipe_halt, .restore_fifo_port, .restore_fifo_valid, .mem_read_start,
        .ext_reg_select, .ext_reg_addr, .receive_data, .trap_indicator,
        .normal_int_enable, .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    ctis_far_model ctis_far_model_i (.sys_clk, .arst_n, .want_trap, .want_int,
        .mem_read_start, .mem_word, .trap_n_pin, .int_n_pin, .proc_mem_bus_rdata);

    // 50 ns clock
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Hang guard, well above the expected run
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic pick(input int k);
        case (k)
            0: return cr_load;
            1: return restore_fifo_valid;
            default: return mem_read_start | ext_reg_select;
        endcase
    endfunction
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // APB master: holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Bounded wait for a one-cycle answer pulse
    task automatic wait_on(input int k);
        int n;
        n = 0;
        #1;
        while (pick(k) !== 1'b1 && n < 8)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        seen = pick(k);
        flushed = pipe_flush;
        @(posedge sys_clk);
    endtask
    task automatic load(input logic [15:0] e);
        wait_on(0);
        chk("cr_load", 32'h1, {31'h0, seen});
        chk("cr_load_addr", {16'h0, e}, {16'h0, cr_load_addr});
    endtask
    task automatic no_load(input int c);
        int n;
        n = 0;
        repeat (c)
        begin
            @(posedge sys_clk);
            #1;
            if (cr_load !== 1'b0) n++;
        end
        chk("no_load", 32'h0, n);
        @(posedge sys_clk);
    endtask
    task automatic ret(input logic [15:0] e);
        restore_return_op <= 1'b1;
        @(posedge sys_clk);
        restore_return_op <= 1'b0;
        load(e);
    endtask
    // Reads the FIFO three times, in pipeline order
    task automatic tii3();
        for (int i = 0; i < 3; i++)
        begin
            transfer_in_internal_op <= 1'b1;
            iru_addr <= ctis_pkg::CTIS_IRU_RESTORE;
            @(posedge sys_clk);
            transfer_in_internal_op <= 1'b0;
            wait_on(1);
            chk("fifo_valid", 32'h1, {31'h0, seen});
            chk("fifo_port", {16'h0, q[i]}, {16'h0, restore_fifo_port});
        end
    endtask
    // New pipeline addresses; kept as the expected FIFO when asked
    task automatic set_pipe(input bit keep);
        logic [31:0] a, b, c;
        a = rnd();
        b = rnd();
        c = rnd();
        pipe_exec_addr <= a[15:0];
        pipe_interp_addr <= b[15:0];
        pipe_fetch_addr <= c[15:0];
        if (keep) q = {a[15:0], b[15:0], c[15:0]};
    endtask

    initial
    begin
        {want_trap, want_int, interp_interruptible, restore_return_op} = 4'h0;
        {transfer_in_internal_op, transfer_in_external_op, receive_op} = 3'h0;
        {psel, penable, pwrite, iru_addr, ext_unit_addr, paddr, pwdata} = '0;
        {pipe_exec_addr, pipe_interp_addr, pipe_fetch_addr, mem_word} = '0;
        arst_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        // Reset values, unmapped offset, enable set-up
        chk("trap_ind", 32'h0, {31'h0, trap_indicator});
        chk("nie", 32'h0, {31'h0, normal_int_enable});
        apb(1'b0, ctis_pkg::CTIS_OFF_ENABLE, 32'h0);
        chk("enable", 32'h0, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'b1, ctis_pkg::CTIS_OFF_ENABLE, 32'h00000007);
        apb(1'b1, ctis_pkg::CTIS_OFF_CTRL, 32'h00000400);
        m_nie = 1;
        chk("nie", m_nie, {31'h0, normal_int_enable});
        $display("test registers done");
        // Interrupt: refused while not interruptible, then taken
        set_pipe(1'b1);
        want_int <= 1'b1;
        no_load(8);
        interp_interruptible <= 1'b1;
        load(ctis_pkg::CTIS_INT_ENTRY);
        m_nie = 0;
        chk("nie", m_nie, {31'h0, normal_int_enable});
        set_pipe(1'b0);
        tii3();
        apb(1'b0, ctis_pkg::CTIS_OFF_STATUS, 32'h0);
        chk("status", 32'h00000002, rd);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, ctis_pkg::CTIS_OFF_CLEAR, 32'h00000007);
        want_int <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq});
        ret(q[0]);
        chk("nie", 32'h1, {31'h0, normal_int_enable});
        ret(q[1]);
        ret(q[2]);
        apb(1'b0, ctis_pkg::CTIS_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h00000400, rd);
        $display("test interrupt done");
        // Trap and interrupt together: trap wins, then stays refused
        set_pipe(1'b1);
        want_trap <= 1'b1;
        want_int <= 1'b1;
        load(ctis_pkg::CTIS_TRAP_ENTRY);
        chk("flush", 32'h1, {31'h0, flushed});
        #1;
        chk("halt", 32'h0, {31'h0, pipe_halt});
        @(posedge sys_clk);
        #1;
        chk("halt", 32'h1, {31'h0, pipe_halt});
        chk("trap_ind", 32'h1, {31'h0, trap_indicator});
        chk("nie", 32'h1, {31'h0, normal_int_enable});
        @(posedge sys_clk);
        set_pipe(1'b0);
        no_load(8);
        tii3();
        apb(1'b1, ctis_pkg::CTIS_OFF_ENABLE, 32'h00000002);
        repeat (2) @(posedge sys_clk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        want_trap <= 1'b0;
        want_int <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ret(q[0]);
        ret(q[1]);
        // Trap pending at the third restore
        want_trap <= 1'b1;
        repeat (2) @(posedge sys_clk);
        ret(ctis_pkg::CTIS_TRAP_ENTRY);
        apb(1'b0, ctis_pkg::CTIS_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h00000C01, rd);
        want_trap <= 1'b0;
        $display("test trap done");
        // External transfers around the scratch-pad range
        for (int i = 0; i < 4; i++)
        begin
            rd = rnd();
            mem_word <= rnd();
            ext_unit_addr <= (i == 3) ? {1'b0, rd[5:0]} : 7'h1F + 7'(i * 7 / 2);
            transfer_in_external_op <= 1'b1;
            @(posedge sys_clk);
            transfer_in_external_op <= 1'b0;
            #1;
            seen = (ext_unit_addr >= 7'h20) && (ext_unit_addr <= 7'h26);
            chk("mem_read", {31'h0, seen}, {31'h0, mem_read_start});
            chk("ext_sel", {31'h0, !seen}, {31'h0, ext_reg_select});
            chk("ext_addr", {25'h0, ext_unit_addr}, {25'h0, ext_reg_addr});
            chk("recv_hold", 32'h0, receive_data);
            @(posedge sys_clk);
        end
        ext_unit_addr <= 7'h22;
        transfer_in_external_op <= 1'b1;
        @(posedge sys_clk);
        transfer_in_external_op <= 1'b0;
        wait_on(2);
        receive_op <= 1'b1;
        @(posedge sys_clk);
        receive_op <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("receive", mem_word, receive_data);
        $display("test scratch pad done");
        print_verdict();
    end
endmodule // ctis_sequencer_tb_top
`default_nettype wire
